//--- common/vjn_pkg.sv
// Shared constants and types of the virtual scan node
package vjn_pkg;

    // --------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------
    localparam int          VJN_ADDR_W         = 8;
    localparam int          VJN_DATA_W         = 32;
    localparam logic [7:0]  VJN_REG_CTRL       = 8'h00;
    localparam logic [7:0]  VJN_REG_STATUS     = 8'h04;
    localparam logic [7:0]  VJN_REG_UPD_COUNT  = 8'h08;
    localparam logic [7:0]  VJN_REG_INDEX      = 8'h0c;

    // --------------------------------------------------------------
    // Field positions and reset values
    // --------------------------------------------------------------
    localparam int          VJN_CTRL_MIRROR_BIT = 0;
    localparam logic        VJN_CTRL_MIRROR_RST = 1'h1;
    localparam int          VJN_INDEX_AUTO_BIT  = 8;
    localparam int          VJN_UPD_COUNT_W     = 16;
    localparam logic [15:0] VJN_UPD_COUNT_RST   = 16'h0000;

    // --------------------------------------------------------------
    // Instruction width limits and node index width
    // --------------------------------------------------------------
    localparam int          VJN_IR_W_MIN = 1;
    localparam int          VJN_IR_W_MAX = 24;
    localparam int          VJN_IR_W_DEF = 1;
    localparam int          VJN_INDEX_W  = 8;

    // --------------------------------------------------------------
    // Virtual flag positions
    // --------------------------------------------------------------
    localparam int          VJN_VF_CDR = 0;
    localparam int          VJN_VF_SDR = 1;
    localparam int          VJN_VF_E1D = 2;
    localparam int          VJN_VF_PDR = 3;
    localparam int          VJN_VF_E2D = 4;
    localparam int          VJN_VF_UDR = 5;
    localparam int          VJN_VF_CIR = 6;
    localparam int          VJN_VF_UIR = 7;
    localparam int          VJN_VF_SIR = 8;
    localparam int          VJN_VF_N   = 9;

    // --------------------------------------------------------------
    // Test access port controller states
    // --------------------------------------------------------------
    typedef enum logic [15:0] {
        VJN_TLR  = 16'h0001,
        VJN_RTI  = 16'h0002,
        VJN_SDRS = 16'h0004,
        VJN_CDR  = 16'h0008,
        VJN_SDR  = 16'h0010,
        VJN_E1DR = 16'h0020,
        VJN_PDR  = 16'h0040,
        VJN_E2DR = 16'h0080,
        VJN_UDR  = 16'h0100,
        VJN_SIRS = 16'h0200,
        VJN_CIR  = 16'h0400,
        VJN_SIR  = 16'h0800,
        VJN_E1IR = 16'h1000,
        VJN_PIR  = 16'h2000,
        VJN_E2IR = 16'h4000,
        VJN_UIR  = 16'h8000
    } vjn_tap_state_type;

endpackage : vjn_pkg

//--- design/vjn_tap_fsm.sv
// Hub state machine tracking the test mode select pin
`timescale 1ns/1ps
module vjn_tap_fsm
    import vjn_pkg::*;
(
    // Link clock and reset
    input  wire logic              tck,
    input  wire logic              tap_rst_n,
    // Mode select
    input  wire logic              tms,
    // State
    output vjn_tap_state_type      state_r,
    output vjn_tap_state_type      state_nxt
);

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        unique case (state_r)
            VJN_TLR:  state_nxt = tms ? VJN_TLR  : VJN_RTI;
            VJN_RTI:  state_nxt = tms ? VJN_SDRS : VJN_RTI;
            VJN_SDRS: state_nxt = tms ? VJN_SIRS : VJN_CDR;
            VJN_CDR:  state_nxt = tms ? VJN_E1DR : VJN_SDR;
            VJN_SDR:  state_nxt = tms ? VJN_E1DR : VJN_SDR;
            VJN_E1DR: state_nxt = tms ? VJN_UDR  : VJN_PDR;
            VJN_PDR:  state_nxt = tms ? VJN_E2DR : VJN_PDR;
            VJN_E2DR: state_nxt = tms ? VJN_UDR  : VJN_SDR;
            VJN_UDR:  state_nxt = tms ? VJN_SDRS : VJN_RTI;
            VJN_SIRS: state_nxt = tms ? VJN_TLR  : VJN_CIR;
            VJN_CIR:  state_nxt = tms ? VJN_E1IR : VJN_SIR;
            VJN_SIR:  state_nxt = tms ? VJN_E1IR : VJN_SIR;
            VJN_E1IR: state_nxt = tms ? VJN_UIR  : VJN_PIR;
            VJN_PIR:  state_nxt = tms ? VJN_E2IR : VJN_PIR;
            VJN_E2IR: state_nxt = tms ? VJN_UIR  : VJN_SIR;
            VJN_UIR:  state_nxt = tms ? VJN_SDRS : VJN_RTI;
            // A glitched code falls back to reset, as five high TMS bits would
            default:  state_nxt = VJN_TLR;
        endcase
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge tck) begin
        if (!tap_rst_n) begin
            state_r <= VJN_TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule : vjn_tap_fsm

//--- design/vjn_node.sv
// Virtual scan node behind the shared test access port
// --------------------------------------------------------------
// --------------------------------------------------------------
`timescale 1ns/1ps
module vjn_node
    import vjn_pkg::*;
#(
    parameter int                     instr_width_param   = VJN_IR_W_DEF,
    parameter string                  auto_index_param    = "YES",
    parameter int                     instance_index      = 0,
    parameter int                     auto_assigned_index = 0,
    parameter logic [255:0]           taken_index_mask    = '0
) (
    // Core clock and register bus
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [VJN_ADDR_W-1:0]   reg_addr,
    input  wire logic [VJN_DATA_W-1:0]   reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [VJN_DATA_W-1:0]   reg_rdata,
    // Device test pins
    input  wire logic                    tck_pin,
    input  wire logic                    tms_pin,
    input  wire logic                    tdi_pin,
    output logic                         tdo_pin_o,
    output logic                         tdo_pin_oe,
    // Hub selection, on the test clock
    input  wire logic                    hub_node_sel,
    input  wire logic                    hub_vir_sel,
    // User glue side
    output logic                         tck_out,
    output logic                         tdi_out,
    input  wire logic                    user_tdo,
    input  wire logic [instr_width_param-1:0] instr_parallel_load,
    output logic      [instr_width_param-1:0] instr_parallel_out,
    // Virtual state flags
    output logic                         node_capture_data_flag,
    output logic                         node_shift_data_flag,
    output logic                         node_exit1_data_flag,
    output logic                         node_pause_data_flag,
    output logic                         node_exit2_data_flag,
    output logic                         node_update_data_flag,
    output logic                         node_capture_instr_flag,
    output logic                         node_update_instr_flag,
    // Mirrored controller states, debug only
    output logic                         tap_reset_flag,
    output logic                         tap_idle_flag,
    output logic                         tap_select_data_flag,
    output logic                         tap_capture_data_flag,
    output logic                         tap_shift_data_flag,
    output logic                         tap_exit1_data_flag,
    output logic                         tap_pause_data_flag,
    output logic                         tap_exit2_data_flag,
    output logic                         tap_update_data_flag,
    output logic                         tap_select_instr_flag,
    output logic                         tap_capture_instr_flag,
    output logic                         tap_shift_instr_flag,
    output logic                         tap_exit1_instr_flag,
    output logic                         tap_pause_instr_flag,
    output logic                         tap_exit2_instr_flag,
    output logic                         tap_update_instr_flag,
    output logic                         tms_mirror
);

    // --------------------------------------------------------------
    // Parameter resolution
    // --------------------------------------------------------------
    localparam int IW = instr_width_param;

    // Out-of-range widths fold into the legal span
    function automatic int clamp_width(input int w);
        if (w < VJN_IR_W_MIN) begin
            return VJN_IR_W_MIN;
        end
        if (w > VJN_IR_W_MAX) begin
            return VJN_IR_W_MAX;
        end
        return w;
    endfunction : clamp_width

    function automatic logic [VJN_INDEX_W-1:0] resolve_index(input string auto_sel, input int req);
        logic [VJN_INDEX_W-1:0] r;
        r = VJN_INDEX_W'(req);
        if (auto_sel == "YES") begin
            r = VJN_INDEX_W'(auto_assigned_index);
        end else if (taken_index_mask[r]) begin
            r = VJN_INDEX_W'(auto_assigned_index);
        end
        return r;
    endfunction : resolve_index

    localparam int                     IW_EFF   = clamp_width(IW);
    localparam logic [VJN_INDEX_W-1:0] NODE_IDX = resolve_index(auto_index_param, instance_index);
    localparam logic                   AUTO_SEL = (auto_index_param == "YES");

    // --------------------------------------------------------------
    // Clock and data passthrough
    // --------------------------------------------------------------
    // Straight wires: any flop here would skew every node's view of the pin
    assign tck_out = tck_pin;
    assign tdi_out = tdi_pin;

    // --------------------------------------------------------------
    // Reset into the test clock domain
    // --------------------------------------------------------------
    logic tck_rst_meta_r;
    logic tck_rst_n_r;

    always_ff @(posedge tck_pin) begin
        tck_rst_meta_r <= rst_n;
        tck_rst_n_r    <= tck_rst_meta_r;
    end

    // --------------------------------------------------------------
    // Mirror enable into the test clock domain
    // --------------------------------------------------------------
    logic mirror_en_r;
    logic mirror_meta_r;
    logic mirror_tck_r;

    always_ff @(posedge tck_pin) begin
        mirror_meta_r <= mirror_en_r;
        mirror_tck_r  <= mirror_meta_r;
    end

    // --------------------------------------------------------------
    // Hub state machine
    // --------------------------------------------------------------
    vjn_tap_state_type tap_state_r;
    vjn_tap_state_type tap_state_nxt;

    vjn_tap_fsm u_hub_fsm (
        .tck       (tck_pin),
        .tap_rst_n (tck_rst_n_r),
        .tms       (tms_pin),
        .state_r   (tap_state_r),
        .state_nxt (tap_state_nxt)
    );

    // --------------------------------------------------------------
    // Flag decode
    // --------------------------------------------------------------
    logic [VJN_VF_N-1:0] vflag_r;
    logic [VJN_VF_N-1:0] vflag_nxt;
    logic [15:0]         tflag_r;
    logic [15:0]         tflag_nxt;
    logic                tms_mirror_r;
    logic                tms_mirror_nxt;
    logic                dr_path;
    logic                ir_path;

    always_comb begin
        dr_path   = hub_node_sel && !hub_vir_sel;
        ir_path   = hub_node_sel && hub_vir_sel;
        vflag_nxt = '0;
        vflag_nxt[VJN_VF_CDR] = dr_path && (tap_state_nxt == VJN_CDR);
        vflag_nxt[VJN_VF_SDR] = dr_path && (tap_state_nxt == VJN_SDR);
        vflag_nxt[VJN_VF_E1D] = dr_path && (tap_state_nxt == VJN_E1DR);
        vflag_nxt[VJN_VF_PDR] = dr_path && (tap_state_nxt == VJN_PDR);
        vflag_nxt[VJN_VF_E2D] = dr_path && (tap_state_nxt == VJN_E2DR);
        vflag_nxt[VJN_VF_UDR] = dr_path && (tap_state_nxt == VJN_UDR);
        vflag_nxt[VJN_VF_CIR] = ir_path && (tap_state_nxt == VJN_CDR);
        vflag_nxt[VJN_VF_UIR] = ir_path && (tap_state_nxt == VJN_UDR);
        vflag_nxt[VJN_VF_SIR] = ir_path && (tap_state_nxt == VJN_SDR);
        // Hidden mirror reads all-zero so nothing can lean on it
        tflag_nxt      = mirror_tck_r ? 16'(tap_state_nxt) : 16'h0000;
        tms_mirror_nxt = mirror_tck_r && tms_pin;
    end

    always_ff @(posedge tck_pin) begin
        if (!tck_rst_n_r) begin
            vflag_r      <= '0;
            tflag_r      <= 16'h0000;
            tms_mirror_r <= 1'h0;
        end else begin
            vflag_r      <= vflag_nxt;
            tflag_r      <= tflag_nxt;
            tms_mirror_r <= tms_mirror_nxt;
        end
    end

    assign node_capture_data_flag  = vflag_r[VJN_VF_CDR];
    assign node_shift_data_flag    = vflag_r[VJN_VF_SDR];
    assign node_exit1_data_flag    = vflag_r[VJN_VF_E1D];
    assign node_pause_data_flag    = vflag_r[VJN_VF_PDR];
    assign node_exit2_data_flag    = vflag_r[VJN_VF_E2D];
    assign node_update_data_flag   = vflag_r[VJN_VF_UDR];
    assign node_capture_instr_flag = vflag_r[VJN_VF_CIR];
    assign node_update_instr_flag  = vflag_r[VJN_VF_UIR];
    assign tap_reset_flag          = tflag_r[0];
    assign tap_idle_flag           = tflag_r[1];
    assign tap_select_data_flag    = tflag_r[2];
    assign tap_capture_data_flag   = tflag_r[3];
    assign tap_shift_data_flag     = tflag_r[4];
    assign tap_exit1_data_flag     = tflag_r[5];
    assign tap_pause_data_flag     = tflag_r[6];
    assign tap_exit2_data_flag     = tflag_r[7];
    assign tap_update_data_flag    = tflag_r[8];
    assign tap_select_instr_flag   = tflag_r[9];
    assign tap_capture_instr_flag  = tflag_r[10];
    assign tap_shift_instr_flag    = tflag_r[11];
    assign tap_exit1_instr_flag    = tflag_r[12];
    assign tap_pause_instr_flag    = tflag_r[13];
    assign tap_exit2_instr_flag    = tflag_r[14];
    assign tap_update_instr_flag   = tflag_r[15];
    assign tms_mirror              = tms_mirror_r;

    // --------------------------------------------------------------
    // Virtual instruction register
    // --------------------------------------------------------------
    // One shift and one hold stage per instance
    logic [IW-1:0] vir_shift_r;
    logic [IW-1:0] vir_shift_nxt;
    logic [IW-1:0] vir_hold_r;
    logic [IW-1:0] vir_hold_nxt;
    logic          upd_tog_r;
    logic          upd_tog_nxt;

    always_comb begin
        vir_shift_nxt = vir_shift_r;
        vir_hold_nxt  = vir_hold_r;
        upd_tog_nxt   = upd_tog_r;
        if (vflag_r[VJN_VF_CIR]) begin
            vir_shift_nxt = instr_parallel_load;
        end else if (vflag_r[VJN_VF_SIR]) begin
            // Shift then fill, so a one-bit register needs no empty slice
            vir_shift_nxt         = vir_shift_r >> 1;
            vir_shift_nxt[IW - 1] = tdi_pin;
        end
        if (vflag_r[VJN_VF_UIR]) begin
            vir_hold_nxt = vir_shift_r;
            upd_tog_nxt  = !upd_tog_r;
        end
        if (tap_state_r == VJN_TLR) begin
            vir_hold_nxt = '0;
        end
    end

    always_ff @(posedge tck_pin) begin
        if (!tck_rst_n_r) begin
            vir_shift_r <= '0;
            vir_hold_r  <= '0;
            upd_tog_r   <= 1'h0;
        end else begin
            vir_shift_r <= vir_shift_nxt;
            vir_hold_r  <= vir_hold_nxt;
            upd_tog_r   <= upd_tog_nxt;
        end
    end

    assign instr_parallel_out = vir_hold_r;

    // --------------------------------------------------------------
    // Serial output pin
    // --------------------------------------------------------------
    // Falling edge gives the host a half period of setup on TDO
    logic tdo_r;
    logic tdo_nxt;
    logic tdo_oe_r;
    logic tdo_oe_nxt;

    always_comb begin
        tdo_nxt    = vflag_r[VJN_VF_SIR] ? vir_shift_r[0] : user_tdo;
        tdo_oe_nxt = vflag_r[VJN_VF_SIR] || vflag_r[VJN_VF_SDR];
    end

    always_ff @(negedge tck_pin) begin
        if (!tck_rst_n_r) begin
            tdo_r    <= 1'h0;
            tdo_oe_r <= 1'h0;
        end else begin
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo_pin_o  = tdo_r;
    assign tdo_pin_oe = tdo_oe_r;

    // --------------------------------------------------------------
    // Update event into the core domain
    // --------------------------------------------------------------
    // Hold word is stable long after the toggle, so it is sampled safely
    logic upd_meta_r;
    logic upd_sync_r;
    logic upd_seen_r;

    always_ff @(posedge core_clk) begin
        upd_meta_r <= upd_tog_r;
        upd_sync_r <= upd_meta_r;
    end

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    logic [IW-1:0]              stat_instr_r;
    logic [IW-1:0]              stat_instr_nxt;
    logic [VJN_UPD_COUNT_W-1:0] upd_cnt_r;
    logic [VJN_UPD_COUNT_W-1:0] upd_cnt_nxt;
    logic                       mirror_en_nxt;
    logic                       upd_seen_nxt;
    logic [VJN_DATA_W-1:0]      rdata_r;
    logic [VJN_DATA_W-1:0]      rdata_nxt;
    logic                       upd_evt;

    always_comb begin
        upd_evt        = upd_sync_r != upd_seen_r;
        upd_seen_nxt   = upd_sync_r;
        stat_instr_nxt = upd_evt ? vir_hold_r : stat_instr_r;
        upd_cnt_nxt    = upd_evt ? upd_cnt_r + 16'h0001 : upd_cnt_r;
        mirror_en_nxt  = mirror_en_r;
        rdata_nxt      = '0;
        if (reg_wr && reg_addr == VJN_REG_CTRL) begin
            mirror_en_nxt = reg_wdata[VJN_CTRL_MIRROR_BIT];
        end
        if (reg_wr && reg_addr == VJN_REG_UPD_COUNT) begin
            // A count arriving with the clear is kept
            upd_cnt_nxt = upd_evt ? 16'h0001 : VJN_UPD_COUNT_RST;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                VJN_REG_CTRL:      rdata_nxt[VJN_CTRL_MIRROR_BIT] = mirror_en_r;
                VJN_REG_STATUS:    rdata_nxt[IW-1:0] = stat_instr_r;
                VJN_REG_UPD_COUNT: rdata_nxt[VJN_UPD_COUNT_W-1:0] = upd_cnt_r;
                VJN_REG_INDEX: begin
                    rdata_nxt[VJN_INDEX_W-1:0]   = NODE_IDX;
                    rdata_nxt[VJN_INDEX_AUTO_BIT] = AUTO_SEL;
                end
                default:           rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mirror_en_r  <= VJN_CTRL_MIRROR_RST;
            stat_instr_r <= '0;
            upd_cnt_r    <= VJN_UPD_COUNT_RST;
            upd_seen_r   <= 1'h0;
            rdata_r      <= '0;
        end else begin
            mirror_en_r  <= mirror_en_nxt;
            stat_instr_r <= stat_instr_nxt;
            upd_cnt_r    <= upd_cnt_nxt;
            upd_seen_r   <= upd_seen_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // IW_EFF only documents the legal span; width is used as given
    logic unused_width;
    assign unused_width = (IW_EFF == IW);

endmodule : vjn_node

//--- verif/vjn_node_checker.sv
// Port checks of the virtual scan node
`timescale 1ns/1ps
module vjn_node_checker
    import vjn_pkg::*;
#(
    parameter int instr_width_param = VJN_IR_W_DEF
) (
    // Clocks, reset and pins
    input wire logic core_clk, rst_n, tck_pin, tdi_pin, tck_out, tdi_out, user_tdo, tdo_pin_o, tdo_pin_oe,
    input wire logic hub_node_sel, hub_vir_sel,
    // Instruction and flags
    input wire logic [instr_width_param-1:0] instr_parallel_load, instr_parallel_out,
    input wire logic node_capture_data_flag, node_shift_data_flag, node_exit1_data_flag, node_pause_data_flag,
    input wire logic node_exit2_data_flag, node_update_data_flag, node_capture_instr_flag, node_update_instr_flag,
    input wire logic tap_reset_flag, tap_shift_data_flag, tap_exit1_data_flag, tap_exit2_data_flag
);
    wire logic [7:0] vf = {node_capture_data_flag, node_shift_data_flag, node_exit1_data_flag, node_pause_data_flag,
                           node_exit2_data_flag, node_update_data_flag, node_capture_instr_flag, node_update_instr_flag};
    wire logic       ld0 = instr_parallel_load[0];
    default clocking cb @(posedge tck_pin); endclocking
    default disable iff (!rst_n);
    sequence s_cap_shift;
        node_capture_instr_flag ##1 tap_shift_data_flag;
    endsequence
    sequence s_quiet_ir;
        !node_update_instr_flag && !tap_reset_flag ##1 !tap_reset_flag;
    endsequence
    a_flags_onehot: assert property ($onehot0(vf)) else $error("virtual flags not one-hot");
    a_deselect_quiet: assert property (!hub_node_sel && !$past(hub_node_sel) |-> vf == 8'h00)
        else $error("flag raised while deselected");
    a_cir_needs_vir: assert property (node_capture_instr_flag |-> $past(hub_vir_sel) && $past(hub_node_sel))
        else $error("instruction capture without instruction path");
    a_load_first: assert property (s_cap_shift |-> tdo_pin_o == $past(ld0))
        else $error("captured instruction bit not shifted out");
    a_ir_hold: assert property (s_quiet_ir |-> $stable(instr_parallel_out))
        else $error("instruction output moved outside update");
    a_upd_after_exit: assert property (node_update_instr_flag |-> $past(tap_exit1_data_flag) || $past(tap_exit2_data_flag))
        else $error("update not preceded by exit");
    a_tdo_shift: assert property (node_shift_data_flag |-> tdo_pin_oe && tdo_pin_o == user_tdo)
        else $error("serial output not driven from user chain");
    a_pins_pass: assert property (@(posedge core_clk) tck_out == tck_pin && tdi_out == tdi_pin)
        else $error("test clock or serial input not passed through");
endmodule : vjn_node_checker

bind vjn_node vjn_node_checker #(.instr_width_param(instr_width_param)) u_chk (
    .core_clk, .rst_n, .tck_pin, .tdi_pin, .tck_out, .tdi_out, .user_tdo, .tdo_pin_o, .tdo_pin_oe, .hub_node_sel,
    .hub_vir_sel, .instr_parallel_load, .instr_parallel_out, .node_capture_data_flag, .node_shift_data_flag,
    .node_exit1_data_flag, .node_pause_data_flag, .node_exit2_data_flag, .node_update_data_flag,
    .node_capture_instr_flag, .node_update_instr_flag, .tap_reset_flag, .tap_shift_data_flag,
    .tap_exit1_data_flag, .tap_exit2_data_flag);

//--- verif/vjn_glue_model.sv
// User glue model: one 8-bit data chain and a bypass bit
`timescale 1ns/1ps
module vjn_glue_model
    import vjn_pkg::*;
#(
    parameter int             W    = 4,
    parameter logic [W-1:0]   LOAD = '0
) (
    // Shared pins, virtual flags and the instruction only, never pause or exit2
    input  wire logic         tck, tdi, cap, sft, upd,
    input  wire logic [W-1:0] instr,
    output logic      [W-1:0] load,
    output logic              user_tdo,
    output logic      [7:0]   dr_q
);
    logic [7:0] chain = 8'h00;
    logic       byp   = 1'b0;
    assign load     = LOAD;
    // Zero instruction has no chain, so the bypass bit keeps the path whole
    assign user_tdo = (instr == '0) ? byp : chain[0];
    always @(posedge tck) begin
        if (cap)
            chain <= 8'h5c;
        if (sft) begin
            chain <= {tdi, chain[7:1]};
            byp   <= tdi;
        end
        if (upd)
            dr_q <= chain;
    end
endmodule : vjn_glue_model

//--- verif/test_vjn_node.sv
// Self-checking bench of the virtual scan node
`timescale 1ns/1ps
module test_vjn_node;
    import vjn_pkg::*;
    logic        core_clk = 0, rst_n = 0, tck_pin = 0, tms_pin = 1, tdi_pin = 0, sel = 1, virtual_instr_register = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0]  ld, ipo;
    logic        tck_out, tdi_out, user_tdo, tdo_o, tdo_oe, cdr, sdr, e1, pdr, e2, udr, cir, uir;
    logic        p_seen = 0, e2_seen = 0;
    logic [7:0]  dr_q;
    int          err_count = 0, checked = 0;
    initial forever #12.5 core_clk = ~core_clk;
    initial begin
        #7;
        forever #15 tck_pin = ~tck_pin;
    end
    vjn_node #(.instr_width_param(4), .auto_assigned_index(3)) DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .tck_pin, .tms_pin, .tdi_pin, .tdo_pin_o(tdo_o), .tdo_pin_oe(tdo_oe),
        .hub_node_sel(sel), .hub_vir_sel(virtual_instr_register), .tck_out, .tdi_out, .user_tdo, .instr_parallel_load(ld),
        .instr_parallel_out(ipo), .node_capture_data_flag(cdr), .node_shift_data_flag(sdr), .node_exit1_data_flag(e1),
        .node_pause_data_flag(pdr), .node_exit2_data_flag(e2), .node_update_data_flag(udr),
        .node_capture_instr_flag(cir), .node_update_instr_flag(uir), .tap_reset_flag(), .tap_idle_flag(),
        .tap_select_data_flag(), .tap_capture_data_flag(), .tap_shift_data_flag(), .tap_exit1_data_flag(),
        .tap_pause_data_flag(), .tap_exit2_data_flag(), .tap_update_data_flag(), .tap_select_instr_flag(),
        .tap_capture_instr_flag(), .tap_shift_instr_flag(), .tap_exit1_instr_flag(), .tap_pause_instr_flag(),
        .tap_exit2_instr_flag(), .tap_update_instr_flag(), .tms_mirror());
    vjn_glue_model #(.W(4), .LOAD(4'h9)) u_glue (.tck(tck_out), .tdi(tdi_out), .cap(cdr), .sft(sdr), .upd(udr),
        .instr(ipo), .load(ld), .user_tdo, .dr_q);
    always @(posedge tck_pin) begin
        p_seen  <= p_seen | pdr;
        e2_seen <= e2_seen | e2;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Reads poll a bounded number of times, since status crosses clock domains
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata;
            if (v === exp) break;
        end
        check(v, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic step(input logic m, input logic d);
        @(posedge tck_pin);
        tms_pin <= m;
        tdi_pin <= d;
    endtask : step
    // From idle: select, capture, n shifts LSB first, optional pause, update, idle
    task automatic scan(input logic iv, input logic [7:0] v, input int n, input logic pause);
        step(1'b1, 1'b0);
        virtual_instr_register <= iv;
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < n; i++) step(i == n - 1, v[i]);
        if (pause) begin
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        #1;
    endtask : scan
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    initial begin
        #500000;
        err_count++;
        results();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(VJN_REG_CTRL, 32'h1);
        rd(VJN_REG_INDEX, 32'h103);
        rd(VJN_REG_UPD_COUNT, 32'h0);
        rd(8'h10, 32'h0);
        repeat (5) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        scan(1'b1, 8'h0a, 4, 1'b0);
        check(32'(ipo), 32'ha);
        rd(VJN_REG_STATUS, 32'ha);
        rd(VJN_REG_UPD_COUNT, 32'h1);
        scan(1'b0, 8'h3b, 8, 1'b1);
        check(32'(dr_q), 32'h3b);
        check({30'h0, p_seen, e2_seen}, 32'h3);
        @(posedge tck_pin);
        sel <= 1'b0;
        scan(1'b1, 8'h05, 4, 1'b0);
        check(32'(ipo), 32'ha);
        rd(VJN_REG_UPD_COUNT, 32'h1);
        wr(VJN_REG_UPD_COUNT, 32'h0);
        rd(VJN_REG_UPD_COUNT, 32'h0);
        @(posedge tck_pin);
        sel <= 1'b1;
        repeat (6) step(1'b1, 1'b0);
        #1 check(32'(ipo), 32'h0);
        wr(VJN_REG_CTRL, 32'h0);
        rd(VJN_REG_CTRL, 32'h0);
        results();
    end
endmodule : test_vjn_node
